// ===== src/bit_shift_rotate_unit.sv
// shift and rotate execution unit with an axi4-lite register slave
//
// Overview of operation
// - rising pulse, clear off: load serial input
// - serial shift moves range up, drops top
// - pulse steady or falling: contents unchanged
// - start word lowest, end word highest
// - clear held: range zero, no shifting
// - serial shift leaves all flags alone
// - area mismatch or start above end: error
// - enabled bidirectional shift via carry and fill
// - condition off or enable off: unchanged
// - reset bit clears range and carry
// - carry takes start bit 00 or end 15
// - left shift zero fill, bit 15 to carry
// - right shift zero fill, bit 00 to carry
// - executed word op updates zero flag
// - right rotate through carry
// - scan end clears carry flag
// - bad indirect address raises error flag
`timescale 1ns/1ps
module bit_shift_rotate_unit
	import shift_unit_pkg::*;
#(
	parameter int NUM_WORDS = RANGE_WORDS
)(
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             irq
);

	localparam int RW = NUM_WORDS * WORD_W;

	// elaboration check: the range word index decode is three bits wide
	if (NUM_WORDS < 1 || NUM_WORDS > 8)
	begin : gBadWords
		$error("NUM_WORDS must be 1..8");
	end

	// register state
	logic [31:0]       commandReg;
	logic [15:0]       controlReg;
	logic [15:0]       operandReg;
	logic [31:0]       rangeReg;
	logic [RW-1:0]     shiftReg;
	flags_t            flagsReg;
	logic [FLAG_W-1:0] irqStatReg;
	logic [FLAG_W-1:0] irqMaskReg;
	logic              pulseLastReg;

	// write channel capture: address and data may arrive in either order
	logic [7:0]  wAddrReg;
	logic [31:0] wDataReg;
	logic [3:0]  wStrbReg;
	logic        wAddrHeldReg;
	logic        wDataHeldReg;
	logic        wrFire;
	logic        execFire;

	assign s_axi_awready = !wAddrHeldReg && !s_axi_bvalid;
	assign s_axi_wready  = !wDataHeldReg && !s_axi_bvalid;
	assign wrFire        = wAddrHeldReg && wDataHeldReg && !s_axi_bvalid;

	// address and data holding registers
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wAddrReg     <= 8'h00;
			wDataReg     <= RESET_WORD;
			wStrbReg     <= 4'h0;
			wAddrHeldReg <= 1'b0;
			wDataHeldReg <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				wAddrReg     <= s_axi_awaddr;
				wAddrHeldReg <= 1'b1;
			end
			else if (wrFire)
				wAddrHeldReg <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				wDataReg     <= s_axi_wdata;
				wStrbReg     <= s_axi_wstrb;
				wDataHeldReg <= 1'b1;
			end
			else if (wrFire)
				wDataHeldReg <= 1'b0;
		end
	end

	// byte-lane merge of a write into an existing word
	function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nu,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				res[8*b +: 8] = nu[8*b +: 8];
		return res;
	endfunction : mergeBytes

	logic [31:0] wMerged;
	logic        wMapped;
	logic [2:0]  wWordIdx;
	assign wWordIdx = 3'((wAddrReg - OFS_RANGE_W0) >> 2);
	always_comb
	begin
		wMapped = 1'b1;
		wMerged = RESET_WORD;
		case (wAddrReg)
			OFS_COMMAND:  wMerged = mergeBytes(commandReg, wDataReg, wStrbReg);
			OFS_CONTROL:  wMerged = mergeBytes({16'h0000, controlReg}, wDataReg, wStrbReg);
			OFS_OPERAND:  wMerged = mergeBytes({16'h0000, operandReg}, wDataReg, wStrbReg);
			OFS_RANGE:    wMerged = mergeBytes(rangeReg, wDataReg, wStrbReg);
			OFS_IRQ_STAT: wMerged = wDataReg;
			OFS_IRQ_MASK: wMerged = mergeBytes({28'h0, irqMaskReg}, wDataReg, wStrbReg);
			default:
			begin
				wMapped = wAddrReg >= OFS_RANGE_W0 && wAddrReg[1:0] == 2'b00
					&& int'(wWordIdx) < NUM_WORDS && wAddrReg < 8'h40;
				wMerged = wDataReg;
			end
		endcase
	end

	// any command write evaluates the instruction once, whether or not the exec bit is set
	assign execFire = wrFire && wAddrReg == OFS_COMMAND;

	// write response
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= AXR_OKAY;
		end
		else if (wrFire)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wMapped ? AXR_OKAY : AXR_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// plain configuration registers
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			commandReg <= RESET_WORD;
			controlReg <= 16'h0000;
			rangeReg   <= RESET_WORD;
			irqMaskReg <= '0;
		end
		else if (wrFire)
		begin
			case (wAddrReg)
				OFS_COMMAND:  commandReg <= wMerged;
				OFS_CONTROL:  controlReg <= wMerged[15:0];
				OFS_RANGE:    rangeReg   <= wMerged;
				OFS_IRQ_MASK: irqMaskReg <= wMerged[FLAG_W-1:0];
				default:      ;
			endcase
		end
	end

	// decoded instruction fields, taken from the incoming command word; range fields from the range register
	opcode_t     op;
	logic        execCond;
	logic        badIndirect;
	logic        pulseNow;
	logic        serialIn;
	logic        clearIn;
	logic        rangeBad;
	logic [AREA_W-1:0] startArea;
	logic [AREA_W-1:0] endArea;
	logic [ADDR_W-1:0] startAddr;
	logic [ADDR_W-1:0] endAddr;
	assign op          = opcode_t'(wMerged[CMD_OP_LSB +: 3]);
	assign execCond    = wMerged[CMD_EXEC_BIT];
	assign badIndirect = wMerged[CMD_IND_BIT] && wMerged[CMD_BAD_BIT];
	assign pulseNow    = wMerged[CMD_PULSE_BIT];
	assign serialIn    = wMerged[CMD_SERIN_BIT];
	assign clearIn     = wMerged[CMD_CLEAR_BIT];
	assign startAddr   = rangeReg[RNG_START_LSB +: ADDR_W];
	assign startArea   = rangeReg[RNG_START_AREA +: AREA_W];
	assign endAddr     = rangeReg[RNG_END_LSB +: ADDR_W];
	assign endArea     = rangeReg[RNG_END_AREA +: AREA_W];
	assign rangeBad    = startArea != endArea || startAddr > endAddr;

	// live range width: words from start to end inclusive, low word at bit 0
	logic [RW-1:0] rangeMask;
	logic [RW-1:0] topBitMask;
	logic [ADDR_W-1:0] spanWords;
	assign spanWords = endAddr - startAddr;
	genvar g;
	generate
		for (g = 0; g < NUM_WORDS; g++)
		begin : gSpan
			assign rangeMask[g*WORD_W +: WORD_W]  = {WORD_W{int'(spanWords) >= g}};
			assign topBitMask[g*WORD_W +: WORD_W] =
				{int'(spanWords) == g, {(WORD_W-1){1'b0}}};
		end
	endgenerate

	// single-word results
	logic [15:0] wordRes;
	logic        wordCarry;
	always_comb
	begin
		wordRes   = operandReg;
		wordCarry = flagsReg.carry;
		case (op)
			OP_SHL: {wordCarry, wordRes} = {operandReg, 1'b0};
			OP_SHR: {wordRes, wordCarry} = {1'b0, operandReg};
			OP_ROL: {wordCarry, wordRes} = {operandReg, flagsReg.carry};
			OP_ROR: {wordRes, wordCarry} = {flagsReg.carry, operandReg};
			default: ;
		endcase
	end
	logic isWordOp;
	assign isWordOp = op == OP_SHL || op == OP_SHR || op == OP_ROL || op == OP_ROR;

	// bidirectional range shift; bit 12 on shifts toward the start word
	logic [RW-1:0] bidirRes;
	logic          bidirCarry;
	logic          topBit;
	assign topBit = |(shiftReg & topBitMask);
	always_comb
	begin
		if (controlReg[CTL_DIR_BIT])
		begin
			bidirRes   = (shiftReg >> 1) | (topBitMask & {RW{controlReg[CTL_FILL_BIT]}});
			bidirCarry = shiftReg[0];
		end
		else
		begin
			bidirRes   = RW'({shiftReg, controlReg[CTL_FILL_BIT]});
			bidirCarry = topBit;
		end
		bidirRes = bidirRes & rangeMask;
	end

	// serial shifter edge memory follows every serial evaluation
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			pulseLastReg <= 1'b0;
		else if (execFire && op == OP_SERIAL)
			pulseLastReg <= pulseNow;
	end

	// shift range storage: instruction evaluation or direct word write
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			shiftReg <= '0;
		else if (execFire && op == OP_SERIAL && !rangeBad)
		begin
			if (clearIn)
				shiftReg <= '0;
			else if (pulseNow && !pulseLastReg)
				shiftReg <= RW'({shiftReg, serialIn}) & rangeMask;
			// otherwise held
		end
		else if (execFire && op == OP_BIDIR && execCond && !rangeBad)
		begin
			if (controlReg[CTL_RESET_BIT])
				shiftReg <= '0;
			else if (controlReg[CTL_EN_BIT])
				shiftReg <= bidirRes;
			// enable off
		end
		else if (wrFire && wMapped && wAddrReg >= OFS_RANGE_W0)
			shiftReg[int'(wWordIdx)*WORD_W +: WORD_W] <= wMerged[15:0];
	end

	// operand word: written by software, replaced by executed word ops
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			operandReg <= 16'h0000;
		else if (execFire && isWordOp && execCond && !badIndirect)
			operandReg <= wordRes;
		else if (wrFire && wAddrReg == OFS_OPERAND)
			operandReg <= wMerged[15:0];
	end

	// flags; serial evaluations never touch them
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			flagsReg <= '0;
		else if (execFire)
		begin
			case (op)
				OP_BIDIR:
					if (rangeBad || badIndirect)
						flagsReg.error <= 1'b1;
					else if (execCond)
					begin
						flagsReg.error <= 1'b0;
						if (controlReg[CTL_RESET_BIT])
							flagsReg.carry <= 1'b0;
						else if (controlReg[CTL_EN_BIT])
							flagsReg.carry <= bidirCarry;
					end
				OP_SHL, OP_SHR, OP_ROL, OP_ROR:
					if (badIndirect)
						flagsReg.error <= 1'b1;
					else if (execCond)
					begin
						flagsReg.error <= 1'b0;
						flagsReg.carry <= wordCarry;
						flagsReg.zero  <= wordRes == 16'h0000;
					end
				OP_SCAN_END: flagsReg.carry <= 1'b0;
				default: ;
			endcase
		end
	end

	// sticky events: set wins over a write-one clear in the same cycle
	logic [FLAG_W-1:0] irqSet;
	assign irqSet[FLG_CARRY] = execFire && isWordOp && execCond && !badIndirect && wordCarry;
	assign irqSet[FLG_ZERO]  = execFire && isWordOp && execCond && !badIndirect
		&& wordRes == 16'h0000;
	assign irqSet[FLG_ERROR] = execFire && (badIndirect
		|| (rangeBad && (op == OP_BIDIR || op == OP_SERIAL)));
	assign irqSet[FLG_DONE]  = execFire;
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			irqStatReg <= '0;
		else
		begin
			if (wrFire && wAddrReg == OFS_IRQ_STAT)
				irqStatReg <= (irqStatReg & ~wMerged[FLAG_W-1:0]) | irqSet;
			else
				irqStatReg <= irqStatReg | irqSet;
		end
	end
	assign irq = |(irqStatReg & irqMaskReg);

	// read channel: one cycle from address to data
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= RESET_WORD;
			s_axi_rresp  <= AXR_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= AXR_OKAY;
			case (s_axi_araddr)
				OFS_COMMAND:  s_axi_rdata <= commandReg;
				OFS_CONTROL:  s_axi_rdata <= {16'h0000, controlReg};
				OFS_OPERAND:  s_axi_rdata <= {16'h0000, operandReg};
				OFS_RANGE:    s_axi_rdata <= rangeReg;
				OFS_FLAGS:    s_axi_rdata <= {29'h0, flagsReg.error, flagsReg.zero,
					flagsReg.carry};
				OFS_RESULT:   s_axi_rdata <= {16'h0000, operandReg};
				OFS_IRQ_STAT: s_axi_rdata <= {28'h0, irqStatReg};
				OFS_IRQ_MASK: s_axi_rdata <= {28'h0, irqMaskReg};
				default:
					if (s_axi_araddr >= OFS_RANGE_W0 && s_axi_araddr[1:0] == 2'b00
						&& int'(3'((s_axi_araddr - OFS_RANGE_W0) >> 2)) < NUM_WORDS
						&& s_axi_araddr < 8'h40)
						s_axi_rdata <= {16'h0000,
							shiftReg[int'(3'((s_axi_araddr - OFS_RANGE_W0) >> 2))*WORD_W +: WORD_W]};
					else
					begin
						s_axi_rdata <= RESET_WORD;
						s_axi_rresp <= AXR_SLVERR;
					end
			endcase
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
	assign s_axi_arready = !s_axi_rvalid;

endmodule : bit_shift_rotate_unit

// ===== src/shift_unit_pkg.sv
// package: constants, types and register map of the shift and rotate unit
package shift_unit_pkg;

	// geometry
	localparam int WORD_W     = 16;
	localparam int RANGE_WORDS = 4;
	localparam int AREA_W     = 2;
	localparam int ADDR_W     = 10;

	// control word bit positions of the bidirectional shifter
	localparam int CTL_DIR_BIT   = 12;
	localparam int CTL_FILL_BIT  = 13;
	localparam int CTL_EN_BIT    = 14;
	localparam int CTL_RESET_BIT = 15;

	// register byte offsets
	localparam logic [7:0] OFS_COMMAND  = 8'h00;
	localparam logic [7:0] OFS_CONTROL  = 8'h04;
	localparam logic [7:0] OFS_OPERAND  = 8'h08;
	localparam logic [7:0] OFS_RANGE    = 8'h0C;
	localparam logic [7:0] OFS_FLAGS    = 8'h10;
	localparam logic [7:0] OFS_RESULT   = 8'h14;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;
	localparam logic [7:0] OFS_RANGE_W0 = 8'h20;

	// command register fields
	localparam int CMD_OP_LSB   = 0;
	localparam int CMD_EXEC_BIT = 4;
	localparam int CMD_IND_BIT  = 5;
	localparam int CMD_BAD_BIT  = 6;
	localparam int CMD_PULSE_BIT = 8;
	localparam int CMD_SERIN_BIT = 9;
	localparam int CMD_CLEAR_BIT = 10;

	// range register fields
	localparam int RNG_START_LSB   = 0;
	localparam int RNG_START_AREA  = 10;
	localparam int RNG_END_LSB     = 16;
	localparam int RNG_END_AREA    = 26;

	// flag positions, shared by flags, status and mask registers
	localparam int FLG_CARRY = 0;
	localparam int FLG_ZERO  = 1;
	localparam int FLG_ERROR = 2;
	localparam int FLG_DONE  = 3;
	localparam int FLAG_W    = 4;

	localparam logic [31:0] RESET_WORD = 32'h0000_0000;

	typedef enum logic [2:0] {
		OP_SERIAL   = 3'h0,
		OP_BIDIR    = 3'h1,
		OP_SHL      = 3'h2,
		OP_SHR      = 3'h3,
		OP_ROL      = 3'h4,
		OP_ROR      = 3'h5,
		OP_SCAN_END = 3'h6
	} opcode_t;

	typedef enum logic [1:0] {
		AXR_OKAY   = 2'h0,
		AXR_SLVERR = 2'h2
	} axi_resp_t;

	typedef struct packed {
		logic carry;
		logic zero;
		logic error;
	} flags_t;

endpackage : shift_unit_pkg

// ===== dv/bit_shift_rotate_unit_monitor.sv
// bus timing checker of the shift and rotate unit
`timescale 1ns/1ps
module bit_shift_rotate_unit_monitor
	import shift_unit_pkg::*;
#(
	parameter int NUM_WORDS = RANGE_WORDS
)(
	input wire logic	clk_sys,
	input wire logic	rst_n,
	input wire logic [7:0]	s_axi_awaddr,
	input wire logic	s_axi_awvalid,
	input wire logic	s_axi_awready,
	input wire logic [31:0]	s_axi_wdata,
	input wire logic [3:0]	s_axi_wstrb,
	input wire logic	s_axi_wvalid,
	input wire logic	s_axi_wready,
	input wire logic [1:0]	s_axi_bresp,
	input wire logic	s_axi_bvalid,
	input wire logic	s_axi_bready,
	input wire logic [7:0]	s_axi_araddr,
	input wire logic	s_axi_arvalid,
	input wire logic	s_axi_arready,
	input wire logic [31:0]	s_axi_rdata,
	input wire logic [1:0]	s_axi_rresp,
	input wire logic	s_axi_rvalid,
	input wire logic	s_axi_rready,
	input wire logic	irq
);
	// one clock domain, so clock and reset are given once
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp)) else $error("write answer dropped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata)) else $error("read answer dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_ar_block: assert property (s_axi_arready == !s_axi_rvalid)
		else $error("read address ready wrong");
	a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
	a_rvalid_cause: assert property ($rose(s_axi_rvalid) |->
		$past(s_axi_arvalid && s_axi_arready)) else $error("read answer unasked");
	// any read past the last range word must be refused with zero data
	a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready
		&& s_axi_araddr >= 8'(32 + 4 * NUM_WORDS) |=> s_axi_rresp == AXR_SLVERR
		&& s_axi_rdata == 32'h0) else $error("unmapped read not refused");
endmodule : bit_shift_rotate_unit_monitor

bind bit_shift_rotate_unit bit_shift_rotate_unit_monitor #(.NUM_WORDS(NUM_WORDS)) mon (
	.clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .irq(irq));

// ===== dv/test_bit_shift_rotate_unit.sv
// self-checking bench of the shift and rotate unit
`timescale 1ns/1ps
`define CHK(g, e) begin cmpCount++; if ((g) !== (e)) begin errors++; \
$display("wrong value at %0t: %h vs %h", $time, g, e); end end
module test_bit_shift_rotate_unit import shift_unit_pkg::*;;
	logic		clk_sys = 1'h0, rst_n = 1'h0, irq;
	logic		awValid = 1'h0, wValid = 1'h0, bReady = 1'h0, arValid = 1'h0;
	logic		rReady = 1'h0, awReady, wReady, bValid, arReady, rValid;
	logic [1:0]	bResp, rResp, bExp, bQ[$];
	logic [7:0]	awAddr = 8'h00, arAddr = 8'h00;
	logic [31:0]	wData = 32'h0, rData, t, seed = 32'h0001_43F1;
	logic [33:0]	expQ[$], mskQ[$], m, e;
	logic [63:0]	r;
	logic [15:0]	v, c;
	logic [2:0]	op;
	logic		cy, z, ex, p, pp, s, clr;
	int		errors = 0, cmpCount = 0;

	bit_shift_rotate_unit #(.NUM_WORDS(4)) dut (
		.clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
		.s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
		.s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
		.s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
		.s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .irq(irq));

	// 200 MHz system clock
	initial
		forever #2.5 clk_sys = ~clk_sys;

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmpCount, errors);
		if (errors == 0 && cmpCount > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test

	// handshakes are sampled mid-cycle, where they equal the next rising edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs = 2'h0);
		bit ah, wh, bh;
		bQ.push_back(rs);
		@(posedge clk_sys);
		awAddr <= a;
		wData <= d;
		awValid <= 1'h1;
		wValid <= 1'h1;
		bReady <= 1'h1;
		for (int n = 0; n < 40; n++)
		begin
			@(negedge clk_sys);
			ah = awValid && awReady;
			wh = wValid && wReady;
			bh = bValid && bReady;
			@(posedge clk_sys);
			if (ah) awValid <= 1'h0;
			if (wh) wValid <= 1'h0;
			if (bh)
			begin
				bReady <= 1'h0;
				return;
			end
		end
		errors++;
		finish_test();
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [33:0] x, input logic [33:0] k = '1);
		bit ah, rh;
		expQ.push_back(x & k);
		mskQ.push_back(k);
		@(posedge clk_sys);
		arAddr <= a;
		arValid <= 1'h1;
		rReady <= 1'h1;
		for (int n = 0; n < 40; n++)
		begin
			@(negedge clk_sys);
			ah = arValid && arReady;
			rh = rValid && rReady;
			@(posedge clk_sys);
			if (ah) arValid <= 1'h0;
			if (rh)
			begin
				rReady <= 1'h0;
				return;
			end
		end
		errors++;
		finish_test();
	endtask : rd

	// oldest note is matched against each accepted answer
	always @(posedge clk_sys)
	begin
		if (rValid && rReady)
		begin
			m = mskQ.pop_front();
			e = expQ.pop_front();
			`CHK({rResp, rData} & m, e)
		end
		// pop once: the compare macro names its expected value twice
		if (bValid && bReady)
		begin
			bExp = bQ.pop_front();
			`CHK(bResp, bExp)
		end
	end

	initial
	begin
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'h1;
		rd(OFS_FLAGS, 34'h0);
		rd(OFS_IRQ_MASK, 34'h0);
		rd(8'h40, {2'h2, 32'h0});
		wr(8'h40, 32'h1, 2'h2);
		$display("test reset and unmapped done");
		wr(OFS_COMMAND, 32'h16);
		cy = 1'h0;
		rd(OFS_FLAGS, 34'h0, 34'h1);
		for (int i = 0; i < 32; i++)
		begin
			t = xs();
			v = t[15:0];
			ex = t[16] || i == 0;
			op = 3'(i % 4 + 2);
			wr(OFS_OPERAND, {16'h0, v});
			if (op[2] && t[17])
			begin
				wr(OFS_COMMAND, 32'h16);
				cy = 1'h0;
			end
			wr(OFS_COMMAND, {27'h0, ex, 1'h0, op});
			if (ex)
			begin
				case (op)
					3'h2: {cy, v} = {v, 1'h0};
					3'h3: {v, cy} = {1'h0, v};
					3'h4: {cy, v} = {v, cy};
					default: {v, cy} = {cy, v};
				endcase
				z = v == 16'h0;
			end
			rd(OFS_RESULT, {18'h0, v});
			rd(OFS_FLAGS, {32'h0, z, cy}, 34'h3);
		end
		$display("test word ops done");
		wr(OFS_IRQ_MASK, 32'h0);
		@(negedge clk_sys);
		`CHK(irq, 1'h0)
		wr(OFS_IRQ_MASK, 32'h8);
		@(negedge clk_sys);
		`CHK(irq, 1'h1)
		wr(OFS_IRQ_STAT, 32'h8);
		@(negedge clk_sys);
		`CHK(irq, 1'h0)
		rd(OFS_IRQ_STAT, 34'h0, 34'h8);
		$display("test interrupt done");
		wr(OFS_RANGE, 32'h0003_0000);
		for (int k = 0; k < 6; k++)
		begin
			r = {xs(), xs()};
			for (int i = 0; i < 4; i++)
				wr(OFS_RANGE_W0 + 8'(4 * i), {16'h0, r[16 * i +: 16]});
			c = {k == 5, k != 4, k[1], k[0], 12'h0};
			wr(OFS_CONTROL, {16'h0, c});
			wr(OFS_COMMAND, 32'h11);
			if (k == 5)
				{cy, r} = 65'h0;
			else if (k != 4 && c[12])
				{r, cy} = {c[13], r};
			else if (k != 4)
				{cy, r} = {r, c[13]};
			for (int i = 0; i < 4; i++)
				rd(OFS_RANGE_W0 + 8'(4 * i), {18'h0, r[16 * i +: 16]});
			rd(OFS_FLAGS, {33'h0, cy}, 34'h5);
		end
		$display("test bidirectional done");
		pp = 1'h0;
		for (int i = 0; i < 24; i++)
		begin
			t = xs();
			s = t[0];
			p = t[1] && i > 0;
			clr = t[4:2] == 3'h0;
			wr(OFS_COMMAND, {21'h0, clr, s, p, 8'h10});
			if (clr)
				r = 64'h0;
			else if (p && !pp)
				r = {r[62:0], s};
			pp = p;
			for (int k = 0; k < 4; k++)
				rd(OFS_RANGE_W0 + 8'(4 * k), {18'h0, r[16 * k +: 16]});
		end
		rd(OFS_FLAGS, {33'h0, cy}, 34'h5);
		$display("test serial done");
		for (int j = 0; j < 3; j++)
		begin
			wr(OFS_RANGE, j == 0 ? 32'h0403_0000 : j == 1 ? 32'h3 : 32'h0003_0000);
			wr(OFS_COMMAND, j == 2 ? 32'h75 : 32'h11);
			rd(OFS_FLAGS, 34'h4, 34'h4);
			wr(OFS_RANGE, 32'h0003_0000);
			wr(OFS_COMMAND, 32'h12);
			rd(OFS_FLAGS, 34'h0, 34'h4);
		end
		$display("test errors done");
		finish_test();
	end
endmodule : test_bit_shift_rotate_unit
